// ===== hdl/meas_alert_consts.svh
`ifndef MEAS_ALERT_CONSTS_SVH
`define MEAS_ALERT_CONSTS_SVH
// ==========================================================
// register word addresses
`define ADDR_STATUS 8'h00
`define ADDR_VOLT_LIM 8'h01
`define ADDR_TEMP_LIM 8'h02
`define ADDR_SOC_LIM 8'h03
`define ADDR_SEL_TEMP 8'h08
`define ADDR_AVG_TEMP 8'h16
`define ADDR_TEMP_PEAK 8'h1A
`define ADDR_CURR_PEAK 8'h1C
`define ADDR_CONFIG 8'h1D
`define ADDR_DIE_TEMP 8'h34
`define ADDR_POWER 8'hB1
`define ADDR_AVG_POWER 8'hB3
`define ADDR_CURR_LIM 8'hB4
`define ADDR_THERM_GAIN 8'h2C
`define ADDR_THERM_OFFSET 8'h2D
`define ADDR_THERM_CURVE 8'hB9
// ==========================================================
// reset values
`define RST_VOLT_LIM 16'hFF00
`define RST_TEMP_LIM 16'h7F80
`define RST_SOC_LIM 16'hFF00
`define RST_CURR_LIM 16'h7F80
`define RST_PEAK 16'h807F
`define RST_STATUS 16'h8080
`define RST_CONFIG 16'h0000
`define RST_THERM_GAIN 16'h0100
// ==========================================================
// config field positions
`define CFG_ALERT_EN 2
`define CFG_TEMP_SEL 15
`define CFG_REMOVE_EN 0
`define CFG_INSERT_EN 1
`define CFG_ONE_PCT_EN 3
`define CFG_VOLT_STICKY 12
`define CFG_TEMP_STICKY 13
`define CFG_SOC_STICKY 14
`define CFG_CURR_STICKY 11
// ==========================================================
// status field positions
`define ST_CURR_LOW 2
`define ST_CURR_HIGH 6
`define ST_VOLT_LOW 8
`define ST_TEMP_LOW 9
`define ST_SOC_LOW 10
`define ST_INSERT 11
`define ST_VOLT_HIGH 12
`define ST_TEMP_HIGH 13
`define ST_SOC_HIGH 14
`define ST_REMOVE 15
`define ST_ONE_PCT 7
// ==========================================================
// thermistor pullup sample period, in us
`define THERM_PERIOD_US 1000
`define CLK_MHZ 50
`define THERM_PERIOD_CYC (`THERM_PERIOD_US * `CLK_MHZ)
`endif

// ===== hdl/meas_alert_pkg.sv
package meas_alert_pkg;
  // thermistor sampling sequence
  typedef enum logic [2:0] {
    TH_IDLE = 3'b001,
    TH_CONNECT = 3'b010,
    TH_CONVERT = 3'b100
  } therm_state_t;
endpackage : meas_alert_pkg

// ===== hdl/measurement_tracking_alert_logic.sv
// Summary of operation
// - current peaks: max upper, min lower byte
// - select bit picks die or thermistor
// - thermistor pullup pulsed, ratio, then off
// - thermistor uses gain/offset/curve; die not
// - die register always die; selected follows
// - average temperature tracks selected temperature
// - temperature peaks reset to 80h/7Fh
// - writing 807Fh restarts temperature peak tracking
// - temperature peaks: max upper, min lower
// - power is current times voltage, filtered
// - alert pin only pulls low
// - insertion/removal alerts need their enables
// - threshold alerts only while enable set
// - one-percent alert on charge bit toggle
// - insertion/removal flags clear only by software
// - threshold flags sticky or self-clearing
// - voltage limits, reset FF00h, disabled
// - temperature limits signed, reset 7F80h
// - charge limits percent, reset FF00h
// - current limits signed, reset 7F80h
// - violations set low/high status flags
// - current peaks reset to 80h/7Fh
`include "meas_alert_consts.svh"
module measurement_tracking_alert_logic
  import meas_alert_pkg::*;
#(
  parameter int THERM_PERIOD = `THERM_PERIOD_CYC,
  parameter int CONVERT_CYC = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  // register access port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  output logic regRvalid,
  // measurement inputs from the converters
  input wire logic measUpdate,
  input wire logic [15:0] dieTempRaw,
  input wire logic [15:0] thermRatio,
  input wire logic [15:0] currentReading,
  input wire logic [15:0] cellVoltageReading,
  input wire logic [15:0] reportedChargeLevel,
  // comparator pins (asynchronous)
  input wire logic removalCmp,
  input wire logic insertionCmp,
  // thermistor pullup control and converter start
  output logic thermPullupEn,
  output logic thermConvStart,
  input wire logic thermConvDone,
  // open-drain alert pin
  output logic alertPinOut,
  output logic alertPinOe
);
  // ==========================================================
  // registers
  logic [15:0] voltLimFf, tempLimFf, socLimFf, currLimFf; // limit registers
  logic [15:0] selTempFf, avgTempFf, dieTempFf; // temperature results
  logic [15:0] tempPeakFf, currPeakFf; // peak trackers
  logic [15:0] powerFf, avgPowerFf; // power results
  logic [15:0] configFf, statusFf; // control and flags
  logic [15:0] gainFf, offsetFf, curveFf; // thermistor conversion
  logic [15:0] thermTempFf; // converted thermistor temperature
  logic [1:0] rmvSyncFf, insSyncFf; // pin synchronisers
  logic prevSocBitFf; // previous charge bit d8
  therm_state_t thStateFf; // thermistor sequencer state
  logic [31:0] thCountFf; // idle and settle cycle counter

  // ==========================================================
  // decode
  // one write strobe per writable register
  // writes to result registers and unmapped places are dropped
  wire wVolt = regWrite && (regAddr == `ADDR_VOLT_LIM);
  wire wTemp = regWrite && (regAddr == `ADDR_TEMP_LIM);
  wire wSoc = regWrite && (regAddr == `ADDR_SOC_LIM);
  wire wCurr = regWrite && (regAddr == `ADDR_CURR_LIM);
  wire wTPeak = regWrite && (regAddr == `ADDR_TEMP_PEAK);
  wire wCPeak = regWrite && (regAddr == `ADDR_CURR_PEAK);
  wire wCfg = regWrite && (regAddr == `ADDR_CONFIG);
  wire wStat = regWrite && (regAddr == `ADDR_STATUS);
  wire wGain = regWrite && (regAddr == `ADDR_THERM_GAIN);
  wire wOff = regWrite && (regAddr == `ADDR_THERM_OFFSET);
  wire wCurve = regWrite && (regAddr == `ADDR_THERM_CURVE);

  // read mux
  // address picks the word handed back on a read strobe
  // a miss reads as zero rather than the last word seen
  logic [15:0] rdMux;
  always_comb begin
    if (regAddr == `ADDR_STATUS) begin
      rdMux = statusFf;
    end else if (regAddr == `ADDR_VOLT_LIM) begin
      rdMux = voltLimFf;
    end else if (regAddr == `ADDR_TEMP_LIM) begin
      rdMux = tempLimFf;
    end else if (regAddr == `ADDR_SOC_LIM) begin
      rdMux = socLimFf;
    end else if (regAddr == `ADDR_SEL_TEMP) begin
      rdMux = selTempFf;
    end else if (regAddr == `ADDR_AVG_TEMP) begin
      rdMux = avgTempFf;
    end else if (regAddr == `ADDR_TEMP_PEAK) begin
      rdMux = tempPeakFf;
    end else if (regAddr == `ADDR_CURR_PEAK) begin
      rdMux = currPeakFf;
    end else if (regAddr == `ADDR_CONFIG) begin
      rdMux = configFf;
    end else if (regAddr == `ADDR_DIE_TEMP) begin
      rdMux = dieTempFf;
    end else if (regAddr == `ADDR_POWER) begin
      rdMux = powerFf;
    end else if (regAddr == `ADDR_AVG_POWER) begin
      rdMux = avgPowerFf;
    end else if (regAddr == `ADDR_CURR_LIM) begin
      rdMux = currLimFf;
    end else if (regAddr == `ADDR_THERM_GAIN) begin
      rdMux = gainFf;
    end else if (regAddr == `ADDR_THERM_OFFSET) begin
      rdMux = offsetFf;
    end else if (regAddr == `ADDR_THERM_CURVE) begin
      rdMux = curveFf;
    end else begin
      rdMux = 16'h0000; // unmapped reads as zero
    end
  end

  // ==========================================================
  // temperature source and conversion
  // thermistor: temp = (ratio*gain)>>14 + offset + curve correction, die path untouched
  // gain 0100h scales the ratio by 1/64
  // the sum wraps silently, so out-of-range settings are the host's concern
  // die results bypass gain, offset and curve entirely
  wire signed [31:0] gainProd = $signed({1'b0, thermRatio}) * $signed(gainFf[15:0]);
  wire signed [15:0] curveTerm = $signed(curveFf) >>> 4;
  wire [15:0] thermConv = 16'(gainProd[29:14]) + offsetFf + 16'(curveTerm);
  wire tempSel = configFf[`CFG_TEMP_SEL];
  wire [15:0] nxtSelTemp = tempSel ? thermTempFf : dieTempRaw;

  // readings, upper bytes used for compares, signed for temperature and current
  // only the upper byte takes part, matching the 8-bit limits
  wire signed [7:0] tempHi = nxtSelTemp[15:8];
  wire signed [7:0] currHi = currentReading[15:8];
  wire [7:0] voltHi = cellVoltageReading[15:8]; // 20 mV steps
  wire [7:0] socHi = reportedChargeLevel[15:8]; // 1 % steps

  // power: current * voltage, upper half kept
  // voltage is zero-extended, so only the current carries a sign
  // the average uses the same 1/8 filter as temperature
  wire signed [32:0] powProd = $signed(currentReading) * $signed({1'b0, cellVoltageReading});
  wire [15:0] nxtPower = powProd[31:16];

  // ==========================================================
  // threshold comparisons
  // strict compares: a reading equal to a limit is inside
  // reset limits sit at the extremes, so nothing trips
  // until the host narrows them
  wire vLow = voltHi < voltLimFf[7:0];
  wire vHigh = voltHi > voltLimFf[15:8];
  wire tLow = tempHi < $signed(tempLimFf[7:0]);
  wire tHigh = tempHi > $signed(tempLimFf[15:8]);
  wire sLow = socHi < socLimFf[7:0];
  wire sHigh = socHi > socLimFf[15:8];
  wire iLow = currHi < $signed(currLimFf[7:0]);
  wire iHigh = currHi > $signed(currLimFf[15:8]);
  wire alertEn = configFf[`CFG_ALERT_EN];

  // peak updates
  // each field only moves outward between restarts
  // reset values 80h/7Fh force the first update into both fields
  wire signed [7:0] temperature_upper_limit = tempPeakFf[15:8];
  wire signed [7:0] temperature_lower_limit = tempPeakFf[7:0];
  wire signed [7:0] cMax = currPeakFf[15:8];
  wire signed [7:0] cMin = currPeakFf[7:0];
  wire [7:0] nxtTMax = (tempHi > temperature_upper_limit) ? tempHi : temperature_upper_limit;
  wire [7:0] nxtTMin = (tempHi < temperature_lower_limit) ? tempHi : temperature_lower_limit;
  wire [7:0] nxtCMax = (currHi > cMax) ? currHi : cMax;
  wire [7:0] nxtCMin = (currHi < cMin) ? currHi : cMin;

  // ==========================================================
  // status flag next value, set wins over software clear
  // a host clear and a fresh violation in one cycle keep the flag
  // threshold flags only set with alert enable, but may auto-clear
  // on any update while their sticky bit is off
  // insertion, removal and one-percent flags never auto-clear
  logic [15:0] setMask, autoClr, nxtStatus;
  always_comb begin
    setMask = 16'h0000;
    autoClr = 16'h0000;
    if (measUpdate && alertEn) begin
      setMask[`ST_VOLT_LOW] = vLow;
      setMask[`ST_VOLT_HIGH] = vHigh;
      setMask[`ST_TEMP_LOW] = tLow;
      setMask[`ST_TEMP_HIGH] = tHigh;
      setMask[`ST_SOC_LOW] = sLow;
      setMask[`ST_SOC_HIGH] = sHigh;
      setMask[`ST_CURR_LOW] = iLow;
      setMask[`ST_CURR_HIGH] = iHigh;
    end
    if (measUpdate) begin
      autoClr[`ST_VOLT_LOW] = !configFf[`CFG_VOLT_STICKY] && !vLow;
      autoClr[`ST_VOLT_HIGH] = !configFf[`CFG_VOLT_STICKY] && !vHigh;
      autoClr[`ST_TEMP_LOW] = !configFf[`CFG_TEMP_STICKY] && !tLow;
      autoClr[`ST_TEMP_HIGH] = !configFf[`CFG_TEMP_STICKY] && !tHigh;
      autoClr[`ST_SOC_LOW] = !configFf[`CFG_SOC_STICKY] && !sLow;
      autoClr[`ST_SOC_HIGH] = !configFf[`CFG_SOC_STICKY] && !sHigh;
      autoClr[`ST_CURR_LOW] = !configFf[`CFG_CURR_STICKY] && !iLow;
      autoClr[`ST_CURR_HIGH] = !configFf[`CFG_CURR_STICKY] && !iHigh;
      setMask[`ST_ONE_PCT] = configFf[`CFG_ONE_PCT_EN] &&
        (reportedChargeLevel[8] != prevSocBitFf);
    end
    // insertion/removal: never auto-cleared
    setMask[`ST_REMOVE] = rmvSyncFf[1] && configFf[`CFG_REMOVE_EN];
    setMask[`ST_INSERT] = insSyncFf[1] && configFf[`CFG_INSERT_EN];
    nxtStatus = statusFf;
    if (wStat) begin
      nxtStatus = statusFf & regWdata; // software clears by writing zero
    end
    nxtStatus = (nxtStatus & ~autoClr) | setMask;
  end

  // pin request: threshold flags count only with alert enable,
  // insertion, removal and one-percent flags always count
  wire alertEvent = |(statusFf & ({16{alertEn}} |
    (16'h0001 << `ST_INSERT) | (16'h0001 << `ST_REMOVE) | (16'h0001 << `ST_ONE_PCT)));

  // ==========================================================
  // thermistor sampling sequencer
  // idle counts out the sample period with the pullup off
  // connect lets the divider settle before the converter starts
  // convert waits for the converter, then drops the pullup
  // a select change mid-sample lets the sample finish first
  // hazard: the converter must answer, or the pullup stays on
  // the idle count free-runs while the die source is chosen,
  // so the first thermistor sample follows the select at once
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      thStateFf <= TH_IDLE;
      thCountFf <= 32'h00000000;
      thermPullupEn <= 1'b0;
      thermConvStart <= 1'b0;
      thermTempFf <= 16'h0000;
    end else begin
      thermConvStart <= 1'b0; // start is a one-cycle pulse
      case (thStateFf)
        TH_IDLE: begin
          thCountFf <= thCountFf + 32'h00000001;
          if (tempSel && thCountFf >= 32'(THERM_PERIOD - 1)) begin
            thCountFf <= 32'h00000000;
            thermPullupEn <= 1'b1;
            thStateFf <= TH_CONNECT;
          end
        end
        TH_CONNECT: begin
          thCountFf <= thCountFf + 32'h00000001;
          if (thCountFf >= 32'(CONVERT_CYC - 1)) begin
            thermConvStart <= 1'b1;
            thStateFf <= TH_CONVERT;
          end
        end
        TH_CONVERT: begin
          if (thermConvDone) begin
            thermPullupEn <= 1'b0;
            thermTempFf <= thermConv;
            thCountFf <= 32'h00000000;
            thStateFf <= TH_IDLE;
          end
        end
        default: begin
          thStateFf <= TH_IDLE; // unreachable codes recover to idle
        end
      endcase
    end
  end

  // ==========================================================
  // measurement results and peaks
  // results only move on a measurement update strobe
  // both averages are first-order filters weighting new samples 1/8
  // the die register ignores the select bit on purpose
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      selTempFf <= 16'h0000;
      dieTempFf <= 16'h0000;
      avgTempFf <= 16'h0000;
      powerFf <= 16'h0000;
      avgPowerFf <= 16'h0000;
      prevSocBitFf <= 1'b0;
    end else if (measUpdate) begin
      dieTempFf <= dieTempRaw;
      selTempFf <= nxtSelTemp;
      avgTempFf <= 16'(avgTempFf - 16'($signed(avgTempFf) >>> 3) + 16'($signed(nxtSelTemp) >>> 3));
      powerFf <= nxtPower;
      avgPowerFf <= 16'(avgPowerFf - 16'($signed(avgPowerFf) >>> 3) + 16'($signed(nxtPower) >>> 3));
      prevSocBitFf <= reportedChargeLevel[8];
    end
  end

  // peak trackers: host write reloads, else follow updates
  // a host write wins over an update in the same cycle
  // writing 807Fh puts a tracker back to its power-up state
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tempPeakFf <= `RST_PEAK;
      currPeakFf <= `RST_PEAK;
    end else begin
      if (wTPeak) begin
        tempPeakFf <= regWdata;
      end else if (measUpdate) begin
        tempPeakFf <= {nxtTMax, nxtTMin};
      end
      if (wCPeak) begin
        currPeakFf <= regWdata;
      end else if (measUpdate) begin
        currPeakFf <= {nxtCMax, nxtCMin};
      end
    end
  end

  // ==========================================================
  // writable configuration
  // limits reset to their disabled extremes
  // gain resets to 0100h, offset and curve to zero
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      voltLimFf <= `RST_VOLT_LIM;
      tempLimFf <= `RST_TEMP_LIM;
      socLimFf <= `RST_SOC_LIM;
      currLimFf <= `RST_CURR_LIM;
      configFf <= `RST_CONFIG;
      gainFf <= `RST_THERM_GAIN;
      offsetFf <= 16'h0000;
      curveFf <= 16'h0000;
    end else begin
      if (wVolt) voltLimFf <= regWdata;
      if (wTemp) tempLimFf <= regWdata;
      if (wSoc) socLimFf <= regWdata;
      if (wCurr) currLimFf <= regWdata;
      if (wCfg) configFf <= regWdata;
      if (wGain) gainFf <= regWdata;
      if (wOff) offsetFf <= regWdata;
      if (wCurve) curveFf <= regWdata;
    end
  end

  // status, synchronisers, alert pin, read data
  // comparator pins pass two flops before the flag logic reads them
  // alert pin: level fixed low, the enable pulls the line down
  // the pin follows the flags one cycle later
  // read data is captured on the strobe and held until the next read
  // status resets with removal and one-percent flags set
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      statusFf <= `RST_STATUS;
      rmvSyncFf <= 2'b00;
      insSyncFf <= 2'b00;
      alertPinOe <= 1'b0;
      alertPinOut <= 1'b0;
      regRdata <= 16'h0000;
      regRvalid <= 1'b0;
    end else begin
      rmvSyncFf <= {rmvSyncFf[0], removalCmp}; // first flop read only here
      insSyncFf <= {insSyncFf[0], insertionCmp}; // first flop read only here
      statusFf <= nxtStatus;
      alertPinOe <= alertEvent;
      alertPinOut <= 1'b0;
      regRvalid <= regRead;
      if (regRead) regRdata <= rdMux;
    end
  end
endmodule : measurement_tracking_alert_logic

// ===== test/meas_alert_monitor.sv
// ==========================================
// port checker for the measurement and alert block
module meas_alert_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic regRvalid,
  input wire logic measUpdate,
  input wire logic thermPullupEn,
  input wire logic thermConvStart,
  input wire logic thermConvDone,
  input wire logic alertPinOut,
  input wire logic alertPinOe
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, reset masks all checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================
  // register port
  AST_RVALID_AFTER_READ: assert property (regRead |=> regRvalid)
    else $error("read strobe not answered");
  AST_RVALID_CAUSE: assert property (regRvalid |-> $past(regRead))
    else $error("read valid without a read");
  AST_RDATA_HOLD: assert property (!regRead |=> $stable(regRdata))
    else $error("read data moved without a read");
  AST_UNMAPPED_ZERO: assert property (regRead && regAddr == 8'h05 |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_LIMIT_READBACK: assert property ((regWrite && regAddr == 8'h01) ##2 (regRead && regAddr == 8'h01)
    |=> regRdata == $past(regWdata, 3)) else $error("voltage limits not kept");
  AST_PEAK_RESTART: assert property ((regWrite && regAddr == 8'h1A && regWdata == 16'h807F && !measUpdate)
    ##2 (regRead && regAddr == 8'h1A && !measUpdate) |=> regRdata == 16'h807F) else $error("peak restart lost");
  // ==========================================
  // pins
  AST_ALERT_ONLY_LOW: assert property (alertPinOut == 1'b0)
    else $error("alert pin driven high");
  AST_PULLUP_OFF: assert property (thermConvDone |-> ##[1:4] !thermPullupEn)
    else $error("pullup left on after conversion");
  AST_START_WITH_PULLUP: assert property (thermConvStart |-> thermPullupEn)
    else $error("converter started with pullup off");
  // main scenarios reached
  cover property ($rose(alertPinOe));
  cover property (thermConvDone);
  cover property (regWrite && regAddr == 8'h1A && regWdata == 16'h807F);
endmodule : meas_alert_monitor

// ===== test/front_end_model.sv
// ==========================================
// converter and alert line seen from outside the block
module front_end_model (
  input wire logic core_clk,
  input wire logic thermConvStart,
  output logic thermConvDone,
  input wire logic alertPinOut,
  input wire logic alertPinOe,
  output logic alertLine
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = 1'b0; // conversion running
  logic [1:0] waitCnt = 2'h0; // cycles left in conversion
  // ratio conversion answers a few cycles after start
  always @(posedge core_clk) begin
    thermConvDone <= 1'b0;
    if (thermConvStart) begin
      busy <= 1'b1;
      waitCnt <= 2'h3;
    end else if (busy) begin
      waitCnt <= waitCnt - 2'h1;
      if (waitCnt == 2'h1) begin
        busy <= 1'b0;
        thermConvDone <= 1'b1;
      end
    end
  end
  // external pullup gives the only high level
  assign alertLine = alertPinOe ? alertPinOut : 1'b1;
endmodule : front_end_model

// ===== test/testbench.sv
// ==========================================
// self-checking bench
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, sys_rst, regWrite, regRead, regRvalid, measUpdate, removalCmp, insertionCmp;
  logic thermPullupEn, thermConvStart, thermConvDone, alertPinOut, alertPinOe, alertLine;
  logic [7:0] regAddr;
  logic [15:0] regWdata, regRdata, dieTempRaw, thermRatio, currentReading, cellVoltageReading, reportedChargeLevel;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // short thermistor sample period keeps the run brief
  measurement_tracking_alert_logic #(.THERM_PERIOD(20), .CONVERT_CYC(16)) i_dut (.core_clk(core_clk),
    .sys_rst(sys_rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .regRvalid(regRvalid), .measUpdate(measUpdate), .dieTempRaw(dieTempRaw),
    .thermRatio(thermRatio), .currentReading(currentReading), .cellVoltageReading(cellVoltageReading),
    .reportedChargeLevel(reportedChargeLevel), .removalCmp(removalCmp), .insertionCmp(insertionCmp),
    .thermPullupEn(thermPullupEn), .thermConvStart(thermConvStart), .thermConvDone(thermConvDone),
    .alertPinOut(alertPinOut), .alertPinOe(alertPinOe));
  front_end_model i_fe (.core_clk(core_clk), .thermConvStart(thermConvStart), .thermConvDone(thermConvDone),
    .alertPinOut(alertPinOut), .alertPinOe(alertPinOe), .alertLine(alertLine));
  // ==========================================
  // clock and cycle ceiling
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ==========================================
  // access tasks
  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge core_clk);
    regWrite = 1'b0;
  endtask : wr
  // read answers one cycle after the strobe
  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge core_clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge core_clk);
    regRead = 1'b0;
    check(16'(regRvalid), 16'h0001);
    check(regRdata, exp);
  endtask : rd
  // one measurement update, then let status and pin settle
  task meas(input logic [15:0] cur, input logic [15:0] soc);
    @(negedge core_clk);
    measUpdate = 1'b1;
    currentReading = cur;
    reportedChargeLevel = soc;
    @(negedge core_clk);
    measUpdate = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : meas
  task print_verdict;
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  // ==========================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    {regWrite, regRead, measUpdate, removalCmp, insertionCmp} = 5'h00;
    regAddr = 8'h00;
    regWdata = 16'h0000;
    dieTempRaw = 16'h1900;
    thermRatio = 16'h4000;
    currentReading = 16'h0000;
    cellVoltageReading = 16'h0800;
    reportedChargeLevel = 16'h0000;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    check(16'(alertLine), 16'h0000);
    rd(8'h01, 16'hFF00);
    rd(8'h02, 16'h7F80);
    rd(8'h03, 16'hFF00);
    rd(8'hB4, 16'h7F80);
    rd(8'h1A, 16'h807F);
    rd(8'h1C, 16'h807F);
    wr(8'h00, 16'h0000);
    rd(8'h00, 16'h0000);
    check(16'(alertLine), 16'h0001);
    meas(16'h2000, 16'h0000);
    rd(8'h00, 16'h0000);
    rd(8'h1C, 16'h2020);
    rd(8'h1A, 16'h1919);
    rd(8'h08, 16'h1900);
    rd(8'h34, 16'h1900);
    wr(8'hB4, 16'h1080);
    wr(8'h1D, 16'h0804);
    meas(16'h2000, 16'h0000);
    rd(8'h00, 16'h0040);
    check(16'(alertPinOe), 16'h0001);
    meas(16'h0500, 16'h0000);
    rd(8'h00, 16'h0040);
    wr(8'h1D, 16'h0004);
    wr(8'hB4, 16'h10F8);
    meas(16'h0500, 16'h0000);
    rd(8'h00, 16'h0000);
    check(16'(alertPinOe), 16'h0000);
    meas(16'hF000, 16'h0000);
    rd(8'h00, 16'h0004);
    rd(8'h1C, 16'h20F0);
    wr(8'h1A, 16'h807F);
    rd(8'h1A, 16'h807F);
    wr(8'h08, 16'hAAAA);
    rd(8'h08, 16'h1900);
    rd(8'h05, 16'h0000); // unmapped place reads zero
    check(16'(thermPullupEn), 16'h0000);
    wr(8'h1D, 16'h8008);
    wr(8'h00, 16'h0000);
    check(16'(thermPullupEn), 16'h0001);
    meas(16'h0000, 16'h0100);
    rd(8'h00, 16'h0080);
    check(16'(alertPinOe), 16'h0001);
    repeat (60) @(negedge core_clk);
    meas(16'h0000, 16'h0100);
    rd(8'h08, 16'h0100);
    rd(8'h34, 16'h1900);
    wr(8'h01, 16'h1234);
    rd(8'h01, 16'h1234);
    // comparators tripped: flags need their enables, then stay until cleared
    wr(8'h00, 16'h0000);
    {removalCmp, insertionCmp} = 2'b11;
    repeat (3) @(negedge core_clk);
    rd(8'h00, 16'h0000);
    wr(8'h1D, 16'h8003);
    rd(8'h00, 16'h8800);
    check(16'(alertPinOe), 16'h0001);
    {removalCmp, insertionCmp} = 2'b00;
    meas(16'h0000, 16'h0100);
    rd(8'h00, 16'h8800);
    wr(8'h00, 16'h0000);
    rd(8'h00, 16'h0000);
    print_verdict();
  end
endmodule : testbench
bind measurement_tracking_alert_logic meas_alert_monitor i_mon (.core_clk(core_clk), .sys_rst(sys_rst),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
  .regRvalid(regRvalid), .measUpdate(measUpdate), .thermPullupEn(thermPullupEn), .thermConvStart(thermConvStart),
  .thermConvDone(thermConvDone), .alertPinOut(alertPinOut), .alertPinOe(alertPinOe));
